// >>> rtl/sft_defs.svh
/*
 Constants for the subsystem flag / external trigger block.
 Assumes inclusion by the top module only; the package does not include it.
*/
// Overview of operation
// - In remote terminal mode a low shared input sets the subsystem flag bit of every transmitted status word.
// - In controller or monitor modes the input is a trigger, ignored in non-enhanced controller and message monitor.
// - In legacy enhanced controller mode with the enable bit set, a rising edge starts the controller.
// - In enhanced controller mode a wait-for-trigger instruction stalls until a rising edge, then proceeds.
// - In word monitor mode with the enable bit set, a rising edge starts monitor operation.
`ifndef SFT_DEFS_SVH
`define SFT_DEFS_SVH
`define SFT_TRIG_EN_BIT   7
`define SFT_CFG1_RESET    16'h0000
`define SFT_SYNC_RESET    1'h1
`endif

// >>> rtl/sft_pkg.sv
/*
 Types for the subsystem flag / external trigger block.
 Assumes the defs header is included alongside.
*/
package sft_pkg;
    typedef enum logic [2:0] {
        SFT_MODE_RT,
        SFT_MODE_BC_LEGACY,
        SFT_MODE_BC_LEGACY_ENH,
        SFT_MODE_BC_ENH,
        SFT_MODE_WORD_MON,
        SFT_MODE_MSG_MON
    } sft_mode_t;

    typedef struct packed {
        logic bc_start;
        logic wait_release;
        logic monitor_start;
    } sft_trig_t;
endpackage : sft_pkg

// >>> rtl/sft_flag_trigger.sv
/*
 Shared subsystem-flag / external-trigger input handling.
 Assumes mode and configuration come from the surrounding terminal logic
 on the same clock; the pin itself is driven from outside.
*/
`timescale 1ns/1ps
`include "sft_defs.svh"
module sft_flag_trigger
    import sft_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire sft_mode_t   mode,
    input  wire logic [15:0] config_reg1,
    input  wire logic        wait_for_trigger_instruction,
    input  wire logic        subsystem_flag_in,
    output logic             status_subsystem_flag,
    output sft_trig_t        trig,
    output logic             sequencer_stall
);
    logic sync1;
    logic sync2;
    logic sync_prev;
    logic rise;
    logic trig_en;
    logic wait_pending;

    // Pin may be asynchronous; idle high so reset cannot fake an edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync1     <= `SFT_SYNC_RESET;
            sync2     <= `SFT_SYNC_RESET;
            sync_prev <= `SFT_SYNC_RESET;
        end
        else
        begin
            sync1     <= subsystem_flag_in;
            sync2     <= sync1;
            sync_prev <= sync2;
        end
    end

    assign rise    = sync2 && !sync_prev;
    assign trig_en = config_reg1[`SFT_TRIG_EN_BIT];

    // Active-low flag, sampled for each status word
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            status_subsystem_flag <= 1'b0;
        else
            status_subsystem_flag <= (mode == SFT_MODE_RT) && !sync2;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            trig <= '0;
        else
        begin
            trig.bc_start      <= rise && trig_en && (mode == SFT_MODE_BC_LEGACY_ENH);
            trig.monitor_start <= rise && trig_en && (mode == SFT_MODE_WORD_MON);
            trig.wait_release  <= rise && wait_pending && (mode == SFT_MODE_BC_ENH);
        end
    end

    // Stall holds from instruction until an edge; edge must follow the instruction
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            wait_pending <= 1'b0;
        else if (mode != SFT_MODE_BC_ENH)
            wait_pending <= 1'b0;
        else if (wait_pending && rise)
            wait_pending <= 1'b0;
        else if (wait_for_trigger_instruction)
            wait_pending <= 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sequencer_stall <= 1'b0;
        else
            sequencer_stall <= (mode == SFT_MODE_BC_ENH)
                               && ((wait_pending && !rise) || (!wait_pending && wait_for_trigger_instruction));
    end

    rise_pulse_a: assert property (@(posedge clock) disable iff (rst)
        rise |=> !rise) else $error("trigger pulse longer than one cycle");
    flag_follow_a: assert property (@(posedge clock) disable iff (rst)
        (mode == SFT_MODE_RT && !sync2) |=> status_subsystem_flag) else $error("flag not set");
    flag_other_a: assert property (@(posedge clock) disable iff (rst)
        (mode != SFT_MODE_RT) |=> !status_subsystem_flag) else $error("flag set outside rt");
    bc_start_a: assert property (@(posedge clock) disable iff (rst)
        (rise && trig_en && mode == SFT_MODE_BC_LEGACY_ENH) |=> trig.bc_start) else $error("bc start missed");
    mon_start_a: assert property (@(posedge clock) disable iff (rst)
        (rise && trig_en && mode == SFT_MODE_WORD_MON) |=> trig.monitor_start) else $error("monitor start missed");
    no_effect_a: assert property (@(posedge clock) disable iff (rst)
        (mode == SFT_MODE_BC_LEGACY || mode == SFT_MODE_MSG_MON) |=> (trig == '0)) else $error("trigger acted");
    disabled_trig_a: assert property (@(posedge clock) disable iff (rst)
        !trig_en |=> !trig.bc_start && !trig.monitor_start) else $error("trigger while disabled");
    wait_release_a: assert property (@(posedge clock) disable iff (rst)
        (wait_pending && rise && mode == SFT_MODE_BC_ENH) |=> trig.wait_release && !sequencer_stall)
        else $error("wait not released");
    wait_hold_a: assert property (@(posedge clock) disable iff (rst)
        (wait_pending && !rise && mode == SFT_MODE_BC_ENH) |=> sequencer_stall) else $error("stall dropped");
    edge_delay_a: assert property (@(posedge clock) disable iff (rst)
        ($rose(sync1) && mode == SFT_MODE_WORD_MON && trig_en) |-> ##2 trig.monitor_start)
        else $error("edge latency wrong");

    // Mode gating: each pulse may only come from its own mode
    bc_mode_only_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode != SFT_MODE_BC_LEGACY_ENH) |=> !trig.bc_start
    ) else $error("bc start outside legacy enhanced mode");

    mon_mode_only_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode != SFT_MODE_WORD_MON) |=> !trig.monitor_start
    ) else $error("monitor start outside word monitor mode");

    release_mode_only_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode != SFT_MODE_BC_ENH) |=> !trig.wait_release
    ) else $error("wait release outside enhanced mode");

    stall_mode_only_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode != SFT_MODE_BC_ENH) |=> !sequencer_stall
    ) else $error("stall outside enhanced mode");

    rt_no_trig_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode == SFT_MODE_RT) |=> (trig == '0)
    ) else $error("trigger pulse in remote terminal mode");

    trig_onehot_a: assert property (
        @(posedge clock) disable iff (rst)
        $onehot0(trig)
    ) else $error("more than one trigger pulse at once");

    // Wait sequencing; an edge before the instruction must not release it
    release_needs_wait_a: assert property (
        @(posedge clock) disable iff (rst)
        !wait_pending |=> !trig.wait_release
    ) else $error("release without pending wait");

    stall_enter_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode == SFT_MODE_BC_ENH && !wait_pending && wait_for_trigger_instruction) |=> sequencer_stall
    ) else $error("stall not raised by wait instruction");

    pending_set_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode == SFT_MODE_BC_ENH && !wait_pending && wait_for_trigger_instruction) |=> wait_pending
    ) else $error("wait not recorded");

    pending_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode == SFT_MODE_BC_ENH && wait_pending && rise) |=> !wait_pending
    ) else $error("wait not cleared by edge");

    stall_idle_a: assert property (
        @(posedge clock) disable iff (rst)
        (!wait_pending && !wait_for_trigger_instruction) |=> !sequencer_stall
    ) else $error("stall without wait");

    stall_pending_a: assert property (
        @(posedge clock) disable iff (rst)
        sequencer_stall |-> wait_pending
    ) else $error("stall without pending wait");

    release_ends_stall_a: assert property (
        @(posedge clock) disable iff (rst)
        trig.wait_release |-> !sequencer_stall
    ) else $error("stall kept at release");

    release_after_wait_a: assert property (
        @(posedge clock) disable iff (rst)
        trig.wait_release |-> $past(wait_pending)
    ) else $error("release without earlier wait");

    early_edge_a: assert property (
        @(posedge clock) disable iff (rst)
        (mode == SFT_MODE_BC_ENH && !wait_pending && rise) |=> !trig.wait_release
    ) else $error("edge before instruction released wait");

    // Pulse shape, synchroniser chain and status flag clear
    no_edge_quiet_a: assert property (
        @(posedge clock) disable iff (rst)
        !rise |=> (trig == '0)
    ) else $error("trigger pulse without edge");

    bc_pulse_one_a: assert property (
        @(posedge clock) disable iff (rst)
        trig.bc_start |=> !trig.bc_start
    ) else $error("bc start longer than one cycle");

    mon_pulse_one_a: assert property (
        @(posedge clock) disable iff (rst)
        trig.monitor_start |=> !trig.monitor_start
    ) else $error("monitor start longer than one cycle");

    rel_pulse_one_a: assert property (
        @(posedge clock) disable iff (rst)
        trig.wait_release |=> !trig.wait_release
    ) else $error("wait release longer than one cycle");

    sync_chain_a: assert property (
        @(posedge clock) disable iff (rst)
        1'b1 |=> (sync2 == $past(sync1))
    ) else $error("second sync stage skipped");

    prev_chain_a: assert property (
        @(posedge clock) disable iff (rst)
        1'b1 |=> (sync_prev == $past(sync2))
    ) else $error("edge history stage skipped");

    flag_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        sync2 |=> !status_subsystem_flag
    ) else $error("flag set while pin high");
endmodule : sft_flag_trigger

// >>> tb/sft_pin_model.sv
/*
 Outside logic driving the shared flag/trigger pin.
 Assumes the bench requests a level; pin moves on falling edges.
*/
`timescale 1ns/1ps
module sft_pin_model (
    input  wire logic clock,
    input  wire logic level_req,
    output logic      subsystem_flag_in
);
    // Level is changed by the bench on falling edges only
    assign subsystem_flag_in = level_req;
endmodule : sft_pin_model

// >>> tb/sft_flag_trigger_tb.sv
/*
 Bench for the flag/trigger block.
 Assumes the pin model drives the pin; all else driven here.
*/
`timescale 1ns/1ps
module sft_flag_trigger_tb
    import sft_pkg::*;
;
    logic        clock, rst, wfti, lvl, pin, flag, stall;
    sft_mode_t   mode;
    logic [15:0] cfg;
    sft_trig_t   trig;
    int          err_total, compares, cyc;
    sft_pin_model i_sft_pin_model (.clock(clock), .level_req(lvl), .subsystem_flag_in(pin));
    sft_flag_trigger i_sft_flag_trigger (.clock(clock), .rst(rst), .mode(mode), .config_reg1(cfg),
        .wait_for_trigger_instruction(wfti), .subsystem_flag_in(pin), .status_subsystem_flag(flag),
        .trig(trig), .sequencer_stall(stall));
    initial
    begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse_case(input sft_mode_t m, input logic en, input logic [2:0] exp);
        logic [2:0] seen;
        int         n;
        mode = m;
        cfg = {8'h00, en, 7'h00};
        lvl = 0;
        repeat (4) @(negedge clock);
        lvl = 1;
        seen = 3'h0;
        n = 0;
        repeat (6)
        begin
            @(negedge clock);
            seen |= trig;
            n += (trig != 3'h0);
        end
        chk({1'h0, seen}, {1'h0, exp});
        chk(n[3:0], {3'h0, exp != 3'h0});
        $display("pulse case %s done", m.name());
    endtask : pulse_case
    task automatic wait_case;
        wfti = 1;
        @(negedge clock);
        wfti = 0;
        @(negedge clock);
        chk({3'h0, stall}, 4'h1);
        pulse_case(SFT_MODE_BC_ENH, 1'h0, 3'h2);
        chk({3'h0, stall}, 4'h0);
        $display("wait case done");
    endtask : wait_case
    task automatic flag_case;
        lvl = 0;
        repeat (5) @(negedge clock);
        chk({3'h0, flag}, 4'h1);
        mode = SFT_MODE_BC_ENH;
        repeat (2) @(negedge clock);
        chk({3'h0, flag}, 4'h0);
        lvl = 1;
        @(negedge clock);
        $display("flag case done");
    endtask : flag_case
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            conclude;
        end
    end
    initial
    begin
        {rst, wfti, lvl, cfg, mode} = {1'h1, 1'h0, 1'h1, 16'h0000, SFT_MODE_RT};
        repeat (16) @(negedge clock);
        rst = 0;
        flag_case;
        pulse_case(SFT_MODE_BC_LEGACY_ENH, 1'h1, 3'h4);
        pulse_case(SFT_MODE_BC_LEGACY_ENH, 1'h0, 3'h0);
        pulse_case(SFT_MODE_WORD_MON, 1'h1, 3'h1);
        pulse_case(SFT_MODE_WORD_MON, 1'h0, 3'h0);
        pulse_case(SFT_MODE_BC_LEGACY, 1'h1, 3'h0);
        pulse_case(SFT_MODE_MSG_MON, 1'h1, 3'h0);
        pulse_case(SFT_MODE_BC_ENH, 1'h1, 3'h0);
        wait_case;
        conclude;
    end
endmodule : sft_flag_trigger_tb
